// ===== lpr_consts.svh
// register addresses, field positions, reset values and constants for the indicator register bank
// Function
// - polarity register at device 0x1E, address 0x8C83, resets to zero (autosense)
// - second indicator level in bits 3:2, first in 1:0, bits 15:4 read zero
// - level code 0 autosense, 1 active high, 2 active low
// - vendor MMD at device 0x1F: identifiers 0x0002/0x0003, devices-present 0x0005/0x0006
// - identifier high is a fixed read-only sixteen-bit value; writes ignored
// - identifier low holds fixed org id, model and revision fields, read-only
// - first devices-present register reads 0x008B and ignores writes
// - second devices-present register reads 0xC000, read-only
// - clock source selections bypass the level select and reach the pin through the pin register
// - status indicator selections drive the pin statically from the signal level
// - swing and role indicators optionally gated by link status per indicator
`ifndef LPR_CONSTS_SVH
`define LPR_CONSTS_SVH
`define LPR_DEV_POLARITY 5'h1E
`define LPR_DEV_VENDOR 5'h1F
`define LPR_ADDR_POLARITY 16'h8C83
`define LPR_ADDR_ID_HIGH 16'h0002
`define LPR_ADDR_ID_LOW 16'h0003
`define LPR_ADDR_PRESENT_FIRST 16'h0005
`define LPR_ADDR_PRESENT_SECOND 16'h0006
`define LPR_POL_RESET 16'h0000
`define LPR_POL_FIRST_LSB 0
`define LPR_POL_SECOND_LSB 2
`define LPR_POL_USED_MASK 16'h000F
`define LPR_PRESENT_FIRST_VALUE 16'h008B
`define LPR_PRESENT_SECOND_VALUE 16'hC000
`define LPR_ID_OUI_LSB 10
`define LPR_ID_MODEL_LSB 4
`define LPR_ID_REV_LSB 0
`endif

// ===== lpr_pkg.sv
// types shared by the indicator register bank
package lpr_pkg;
  typedef enum logic [1:0] {
    LPR_LEVEL_AUTO = 2'h0,
    LPR_LEVEL_HIGH = 2'h1,
    LPR_LEVEL_LOW = 2'h2,
    LPR_LEVEL_RSVD = 2'h3
  } lpr_level_t;
  typedef enum logic [4:0] {
    LPR_SRC_ON = 5'h0D,
    LPR_SRC_OFF = 5'h0E,
    LPR_SRC_HIGH_SWING = 5'h10,
    LPR_SRC_LOW_SWING = 5'h11,
    LPR_SRC_LEADER = 5'h12,
    LPR_SRC_FOLLOWER = 5'h13,
    LPR_SRC_MISMATCH = 5'h14,
    LPR_SRC_NEG_LINK_OK = 5'h15,
    LPR_SRC_NEG_DONE = 5'h16,
    LPR_SRC_TICK = 5'h17,
    LPR_SRC_LOCAL_RX = 5'h18,
    LPR_SRC_REMOTE_RX = 5'h19,
    LPR_SRC_REF_CLK = 5'h1A,
    LPR_SRC_TX_CLK = 5'h1B,
    LPR_SRC_FAST_CLK = 5'h1C
  } lpr_source_t;
endpackage : lpr_pkg

// ===== lpr_indicator.sv
// one indicator pin: source select, link gating and polarity
`timescale 1ns/10ps
module lpr_indicator (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_enable,
  // configuration
  input wire logic [4:0] source_select,
  input wire logic link_gate,
  input wire logic [1:0] level_select,
  input wire logic autosense_high,
  // status sources
  input wire logic controller_level,
  input wire logic link_up,
  input wire logic high_swing_indicator,
  input wire logic low_swing_indicator,
  input wire logic leader_role,
  input wire logic link_config_mismatch,
  input wire logic negotiated_link_ok,
  input wire logic negotiation_done,
  input wire logic timestamp_tick,
  input wire logic local_receiver_ok,
  input wire logic remote_receiver_ok,
  input wire logic ref_clock_out,
  input wire logic transmit_clock_out,
  input wire logic fast_clock_out,
  // pin
  output logic pin
);
  logic active;
  logic is_clock;
  logic clock_level;
  logic next_pin;

  always_comb begin
    active = controller_level;
    is_clock = 1'b0;
    clock_level = 1'b0;
    unique case (source_select)
      lpr_pkg::LPR_SRC_ON: active = 1'b1;
      lpr_pkg::LPR_SRC_OFF: active = 1'b0;
      lpr_pkg::LPR_SRC_HIGH_SWING: active = high_swing_indicator & (link_up | ~link_gate);
      lpr_pkg::LPR_SRC_LOW_SWING: active = low_swing_indicator & (link_up | ~link_gate);
      lpr_pkg::LPR_SRC_LEADER: active = leader_role & (link_up | ~link_gate);
      lpr_pkg::LPR_SRC_FOLLOWER: active = ~leader_role & (link_up | ~link_gate);
      lpr_pkg::LPR_SRC_MISMATCH: active = link_config_mismatch;
      lpr_pkg::LPR_SRC_NEG_LINK_OK: active = negotiated_link_ok;
      lpr_pkg::LPR_SRC_NEG_DONE: active = negotiation_done;
      lpr_pkg::LPR_SRC_TICK: active = timestamp_tick;
      lpr_pkg::LPR_SRC_LOCAL_RX: active = local_receiver_ok;
      lpr_pkg::LPR_SRC_REMOTE_RX: active = remote_receiver_ok;
      lpr_pkg::LPR_SRC_REF_CLK: begin
        is_clock = 1'b1;
        clock_level = ref_clock_out;
      end
      lpr_pkg::LPR_SRC_TX_CLK: begin
        is_clock = 1'b1;
        clock_level = transmit_clock_out;
      end
      lpr_pkg::LPR_SRC_FAST_CLK: begin
        is_clock = 1'b1;
        clock_level = fast_clock_out;
      end
      default: active = controller_level;
    endcase
  end

  // clocks bypass polarity; status levels pass through the level select
  always_comb begin
    if (is_clock) begin
      next_pin = clock_level;
    end else begin
      unique case (level_select)
        lpr_pkg::LPR_LEVEL_HIGH: next_pin = active;
        lpr_pkg::LPR_LEVEL_LOW: next_pin = ~active;
        default: next_pin = autosense_high ? active : ~active;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pin <= 1'b0;
    end else if (clock_enable) begin
      pin <= next_pin;
    end
  end
endmodule : lpr_indicator

// ===== lpr_regbank.sv
// indicator polarity and vendor identification register bank on MMD access
`timescale 1ns/10ps
`include "lpr_consts.svh"
module lpr_regbank #(
  // arbitrary identification values
  parameter logic [15:0] ID_HIGH = 16'h1234,
  parameter logic [5:0] ID_OUI = 6'h15,
  parameter logic [5:0] ID_MODEL = 6'h03,
  parameter logic [3:0] ID_REVISION = 4'h2
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_enable,
  // mmd register access
  input wire logic [4:0] mmd_device,
  input wire logic [15:0] mmd_address,
  input wire logic mmd_write,
  input wire logic mmd_read,
  input wire logic [15:0] mmd_write_data,
  output logic [15:0] mmd_read_data,
  output logic mmd_read_valid,
  output logic mmd_hit,
  // indicator source selects, link gates, autosense results and controller levels from the function registers
  input wire logic [4:0] first_indicator_source_select,
  input wire logic [4:0] second_indicator_source_select,
  input wire logic first_indicator_link_gate,
  input wire logic second_indicator_link_gate,
  input wire logic first_autosense_high,
  input wire logic second_autosense_high,
  input wire logic first_controller_level,
  input wire logic second_controller_level,
  // status sources
  input wire logic link_up,
  input wire logic high_swing_indicator,
  input wire logic low_swing_indicator,
  input wire logic leader_role,
  input wire logic link_config_mismatch,
  input wire logic negotiated_link_ok,
  input wire logic negotiation_done,
  input wire logic timestamp_tick,
  input wire logic local_receiver_ok,
  input wire logic remote_receiver_ok,
  input wire logic ref_clock_out,
  input wire logic transmit_clock_out,
  input wire logic fast_clock_out,
  // indicator pins
  output logic first_indicator_pin,
  output logic second_indicator_pin
);
  logic [15:0] indicator_polarity_config;
  logic [15:0] mmd_identifier_low;
  logic sel_polarity;
  logic sel_vendor;
  logic known;
  logic [15:0] next_read_data;

  assign sel_polarity = (mmd_device == `LPR_DEV_POLARITY) && (mmd_address == `LPR_ADDR_POLARITY);
  assign sel_vendor = (mmd_device == `LPR_DEV_VENDOR);
  assign mmd_identifier_low = {ID_OUI, ID_MODEL, ID_REVISION};

  // only the two level fields take writes; reserved bits stay zero
  always_ff @(posedge clock) begin
    if (!resetn) begin
      indicator_polarity_config <= `LPR_POL_RESET;
    end else if (clock_enable && mmd_write && sel_polarity) begin
      indicator_polarity_config <= mmd_write_data & `LPR_POL_USED_MASK;
    end
  end

  // read mux; read-only registers have no write path
  always_comb begin
    next_read_data = 16'h0000;
    known = 1'b1;
    if (sel_polarity) begin
      next_read_data = indicator_polarity_config;
    end else if (sel_vendor && mmd_address == `LPR_ADDR_ID_HIGH) begin
      next_read_data = ID_HIGH;
    end else if (sel_vendor && mmd_address == `LPR_ADDR_ID_LOW) begin
      next_read_data = mmd_identifier_low;
    end else if (sel_vendor && mmd_address == `LPR_ADDR_PRESENT_FIRST) begin
      next_read_data = `LPR_PRESENT_FIRST_VALUE;
    end else if (sel_vendor && mmd_address == `LPR_ADDR_PRESENT_SECOND) begin
      next_read_data = `LPR_PRESENT_SECOND_VALUE;
    end else begin
      known = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      mmd_read_data <= 16'h0000;
      mmd_read_valid <= 1'b0;
      mmd_hit <= 1'b0;
    end else if (clock_enable) begin
      mmd_read_valid <= mmd_read;
      mmd_hit <= (mmd_read | mmd_write) & known;
      if (mmd_read) begin
        mmd_read_data <= next_read_data;
      end
    end
  end

  lpr_indicator first_unit (
    .clock(clock),
    .resetn(resetn),
    .clock_enable(clock_enable),
    .source_select(first_indicator_source_select),
    .link_gate(first_indicator_link_gate),
    .level_select(indicator_polarity_config[`LPR_POL_FIRST_LSB +: 2]),
    .autosense_high(first_autosense_high),
    .controller_level(first_controller_level),
    .link_up(link_up),
    .high_swing_indicator(high_swing_indicator),
    .low_swing_indicator(low_swing_indicator),
    .leader_role(leader_role),
    .link_config_mismatch(link_config_mismatch),
    .negotiated_link_ok(negotiated_link_ok),
    .negotiation_done(negotiation_done),
    .timestamp_tick(timestamp_tick),
    .local_receiver_ok(local_receiver_ok),
    .remote_receiver_ok(remote_receiver_ok),
    .ref_clock_out(ref_clock_out),
    .transmit_clock_out(transmit_clock_out),
    .fast_clock_out(fast_clock_out),
    .pin(first_indicator_pin)
  );

  lpr_indicator second_unit (
    .clock(clock),
    .resetn(resetn),
    .clock_enable(clock_enable),
    .source_select(second_indicator_source_select),
    .link_gate(second_indicator_link_gate),
    .level_select(indicator_polarity_config[`LPR_POL_SECOND_LSB +: 2]),
    .autosense_high(second_autosense_high),
    .controller_level(second_controller_level),
    .link_up(link_up),
    .high_swing_indicator(high_swing_indicator),
    .low_swing_indicator(low_swing_indicator),
    .leader_role(leader_role),
    .link_config_mismatch(link_config_mismatch),
    .negotiated_link_ok(negotiated_link_ok),
    .negotiation_done(negotiation_done),
    .timestamp_tick(timestamp_tick),
    .local_receiver_ok(local_receiver_ok),
    .remote_receiver_ok(remote_receiver_ok),
    .ref_clock_out(ref_clock_out),
    .transmit_clock_out(transmit_clock_out),
    .fast_clock_out(fast_clock_out),
    .pin(second_indicator_pin)
  );
endmodule : lpr_regbank

// ===== lpr_regbank_checker.sv
// concurrent checks on the register access side of the indicator register bank
`timescale 1ns/10ps
module lpr_regbank_checker #(
  parameter logic [15:0] ID_HIGH = 16'h1234,
  parameter logic [5:0] ID_OUI = 6'h15,
  parameter logic [5:0] ID_MODEL = 6'h03,
  parameter logic [3:0] ID_REVISION = 4'h2
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_enable,
  // register access
  input wire logic [4:0] mmd_device,
  input wire logic [15:0] mmd_address,
  input wire logic mmd_read,
  input wire logic [15:0] mmd_read_data,
  input wire logic mmd_read_valid,
  input wire logic mmd_hit
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic rd, v1f;
  assign rd = mmd_read && clock_enable;
  assign v1f = rd && mmd_device == 5'h1F;
  AST_RV_ONE: assert property (rd |=> mmd_read_valid)
    else $error("read not answered");
  AST_RV_CAUSE: assert property (mmd_read_valid && $past(clock_enable) |-> $past(rd))
    else $error("read valid without read");
  AST_RV_DROP: assert property (rd ##1 (!mmd_read && clock_enable) |=> !mmd_read_valid)
    else $error("read valid too long");
  AST_ID_HIGH: assert property (v1f && mmd_address == 16'h0002 |=> mmd_hit && mmd_read_data == ID_HIGH)
    else $error("identifier high wrong");
  AST_ID_LOW: assert property (v1f && mmd_address == 16'h0003 |=> mmd_read_data == {ID_OUI, ID_MODEL, ID_REVISION})
    else $error("identifier low wrong");
  AST_PRESENT_ONE: assert property (v1f && mmd_address == 16'h0005 |=> mmd_read_data == 16'h008B)
    else $error("first presence word wrong");
  AST_PRESENT_TWO: assert property (v1f && mmd_address == 16'h0006 |=> mmd_read_data == 16'hC000)
    else $error("second presence word wrong");
  AST_POL_RSVD: assert property (rd && mmd_device == 5'h1E && mmd_address == 16'h8C83 |=>
    mmd_hit && mmd_read_data[15:4] == 12'h000) else $error("polarity upper bits not zero");
  AST_UNMAPPED: assert property (rd && mmd_device == 5'h1E && mmd_address != 16'h8C83 |=>
    !mmd_hit && mmd_read_data == 16'h0000) else $error("unmapped read answered");
endmodule : lpr_regbank_checker

bind lpr_regbank lpr_regbank_checker #(.ID_HIGH(ID_HIGH), .ID_OUI(ID_OUI), .ID_MODEL(ID_MODEL),
  .ID_REVISION(ID_REVISION)) u_chk (.clock(clock), .resetn(resetn), .clock_enable(clock_enable),
  .mmd_device(mmd_device), .mmd_address(mmd_address), .mmd_read(mmd_read), .mmd_read_data(mmd_read_data),
  .mmd_read_valid(mmd_read_valid), .mmd_hit(mmd_hit));

// ===== lpr_regbank_tb.sv
// self-checking bench for the indicator register bank
`timescale 1ns/10ps
module lpr_regbank_tb;
  // arbitrary identification values
  localparam logic [15:0] IDH = 16'h4C21;
  localparam logic [5:0] OUI = 6'h2A;
  localparam logic [5:0] MDL = 6'h11;
  localparam logic [3:0] REV = 4'h6;
  logic clock = 1'b0, resetn = 1'b0, ce = 1'b1, mw = 1'b0, mr = 1'b0, rv, hit, p0, p1, e0, e1, q0, q1;
  logic [4:0] dev = 5'h00, s0 = 5'h00, s1 = 5'h00;
  logic [15:0] adr = 16'h0000, wd = 16'h0000, pol = 16'h0000, rdat, e;
  logic [12:0] r = 13'h0000;
  logic [5:0] c = 6'h00;
  logic [31:0] seed = 32'h0000D01D, x, y;
  logic [20:0] tbl [7] = '{21'h1E8C83, 21'h1F0002, 21'h1F0003, 21'h1F0005, 21'h1F0006, 21'h1E0005, 21'h1F8C83};
  int n_fail = 0, compares = 0;
  lpr_regbank #(.ID_HIGH(IDH), .ID_OUI(OUI), .ID_MODEL(MDL), .ID_REVISION(REV)) DUT (
    .clock(clock), .resetn(resetn), .clock_enable(ce), .mmd_device(dev), .mmd_address(adr), .mmd_write(mw),
    .mmd_read(mr), .mmd_write_data(wd), .mmd_read_data(rdat), .mmd_read_valid(rv), .mmd_hit(hit),
    .first_indicator_source_select(s0), .second_indicator_source_select(s1), .first_indicator_link_gate(c[0]),
    .second_indicator_link_gate(c[1]), .first_autosense_high(c[2]), .second_autosense_high(c[3]),
    .first_controller_level(c[4]), .second_controller_level(c[5]), .link_up(r[0]), .high_swing_indicator(r[1]),
    .low_swing_indicator(r[2]), .leader_role(r[3]), .link_config_mismatch(r[4]), .negotiated_link_ok(r[5]),
    .negotiation_done(r[6]), .timestamp_tick(r[7]), .local_receiver_ok(r[8]), .remote_receiver_ok(r[9]),
    .ref_clock_out(r[10]), .transmit_clock_out(r[11]), .fast_clock_out(r[12]), .first_indicator_pin(p0),
    .second_indicator_pin(p1));
  initial forever #25 clock = ~clock;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // expected pin level from source, gate, level code, autosense result and controller level
  function automatic logic f(logic [4:0] s, logic g, logic [1:0] lv, logic ash, logic ctl);
    logic sig;
    sig = ctl;
    if (s == 5'h0D) sig = 1'b1;
    if (s == 5'h0E) sig = 1'b0;
    if (s >= 5'h10 && s <= 5'h1C) sig = r[s - 5'h10];
    // swing and leader codes sit one bit above their code offset
    if (s >= 5'h10 && s <= 5'h12) sig = r[s - 5'h0F];
    if (s == 5'h13) sig = !r[3];
    if (s >= 5'h10 && s <= 5'h13 && g) sig = sig & r[0];
    if (s >= 5'h1A && s <= 5'h1C) return sig;
    return lv == 2'h1 ? sig : lv == 2'h2 ? !sig : (ash ? sig : !sig);
  endfunction : f
  function automatic logic [15:0] exp_rd(int j);
    case (j)
      0: return pol;
      1: return IDH;
      2: return {OUI, MDL, REV};
      3: return 16'h008B;
      4: return 16'hC000;
      default: return 16'h0000;
    endcase
  endfunction : exp_rd
  task automatic chk(string nm, logic [15:0] ex, logic [15:0] g);
    compares++;
    if (g !== ex) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk
  task automatic chk_pin(string nm, logic ex, logic g);
    compares++;
    if (g !== ex) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", nm, ex, g);
    end
  endtask : chk_pin
  task automatic acc(logic [20:0] da, logic w, logic [15:0] d, logic rd);
    @(negedge clock);
    {dev, adr} = da;
    mw = w;
    wd = d;
    mr = rd;
    @(negedge clock);
    mw = 1'b0;
    mr = 1'b0;
  endtask : acc
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  initial begin
    #500000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    // read and write together: read returns the old word, then the write lands
    for (int k = 0; k < 21; k++) begin
      x = rnd();
      e = exp_rd(k % 7);
      acc(tbl[k % 7], 1'b1, x[15:0], 1'b1);
      chk("read_data", e, rdat);
      chk("hit", {15'h0000, k % 7 < 5}, {15'h0000, hit});
      chk("read_valid", 16'h0001, {15'h0000, rv});
      if (k % 7 == 0) pol = x[15:0] & 16'h000F;
    end
    $display("test registers done");
    for (int i = 0; i < 300; i++) begin
      ce = 1'b1;
      x = rnd();
      y = rnd();
      if (i % 6 == 0) begin
        acc(tbl[0], 1'b1, y[15:0], 1'b0);
        pol = y[15:0] & 16'h000F;
      end
      @(negedge clock);
      q0 = f(s0, c[0], pol[1:0], c[2], c[4]);
      q1 = f(s1, c[1], pol[3:2], c[3], c[5]);
      {ce, c, s1, s0} = {x[17:16] != 2'h0, x[15:0]};
      r = y[28:16];
      @(negedge clock);
      e0 = ce ? f(s0, c[0], pol[1:0], c[2], c[4]) : q0;
      e1 = ce ? f(s1, c[1], pol[3:2], c[3], c[5]) : q1;
      chk_pin("first_pin", e0, p0);
      chk_pin("second_pin", e1, p1);
    end
    $display("test pins done");
    // write while frozen is dropped
    ce = 1'b0;
    acc(tbl[0], 1'b1, 16'h0009, 1'b0);
    ce = 1'b1;
    acc(tbl[0], 1'b0, 16'h0000, 1'b1);
    chk("frozen_write", pol, rdat);
    // reset in mid-run clears polarity, read data and pins
    @(negedge clock);
    resetn = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    pol = 16'h0000;
    chk_pin("reset_first_pin", 1'b0, p0);
    chk_pin("reset_second_pin", 1'b0, p1);
    chk("reset_read_data", 16'h0000, rdat);
    acc(tbl[0], 1'b0, 16'h0000, 1'b1);
    chk("reset_polarity", pol, rdat);
    $display("test reset done");
    final_report();
  end
endmodule : lpr_regbank_tb
